//--- include/spdc_pkg.sv
// shared constants and carriers of the trailer, sync condition and diversity block
//------------------------------------------------------------
//------------------------------------------------------------
package spdc_pkg;
  // register offsets
  localparam logic [7:0] SPDC_ADDR_TRAILER = 8'h44;
  localparam logic [7:0] SPDC_ADDR_COND_A = 8'h45;
  localparam logic [7:0] SPDC_ADDR_ENERGY_TH = 8'h46;
  localparam logic [7:0] SPDC_ADDR_TOL = 8'h47;
  localparam logic [7:0] SPDC_ADDR_DIV_CTL = 8'h48;
  localparam logic [7:0] SPDC_ADDR_DIV_RES = 8'h49;
  localparam logic [7:0] SPDC_ADDR_ANT1_ENERGY = 8'h4a;
  localparam logic [7:0] SPDC_ADDR_ANT2_ENERGY = 8'h4b;
  // values after reset
  localparam logic [7:0] SPDC_RST_TRAILER = 8'h12;
  localparam logic [7:0] SPDC_RST_ZERO = 8'h00;
  localparam logic [1:0] SPDC_RST_RESULT = 2'h1;
  // field positions
  localparam int SPDC_TRL_EN_BIT = 0;
  localparam int SPDC_TRL_PAT_LSB = 1;
  localparam int SPDC_TRL_LEN_LSB = 4;
  localparam int SPDC_ENERGY_EN_BIT = 7;
  localparam int SPDC_SW_TOL_LSB = 4;
  localparam int SPDC_PB_TOL_LSB = 0;
  localparam int SPDC_DIV_EN_BIT = 0;
  localparam int SPDC_SW_TYPE_BIT = 1;
  localparam int SPDC_INV_TRX_BIT = 2;
  localparam int SPDC_INV_ANT_BIT = 3;
  localparam int SPDC_DONE_BIT = 7;
  localparam int SPDC_RSV_LSB = 2;
  // codes
  localparam logic [5:0] SPDC_PRE_LEN_MAX = 6'h20;
  localparam logic [1:0] SPDC_PAT_01 = 2'h0;
  localparam logic [1:0] SPDC_PAT_10 = 2'h1;
  localparam logic [1:0] SPDC_PAT_CRC = 2'h2;
  localparam logic [1:0] SPDC_PAT_RSV = 2'h3;
  localparam logic [1:0] SPDC_ANT1 = 2'h1;
  localparam logic [1:0] SPDC_ANT2 = 2'h2;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } spdc_byte_t;

  typedef struct packed {
    logic candidate;
    logic [5:0] pre_errs;
    logic [5:0] sw_errs;
    logic [7:0] energy;
  } spdc_sync_t;
endpackage

//--- hw/spdc_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/10ps
module spdc_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  // clock
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // fill side
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // drain side
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [CW-1:0] count_reg;
  logic ready_reg;
  logic valid_reg;

  wire push = i_in_valid && ready_reg;
  wire pop = valid_reg && i_out_ready;
  wire [CW-1:0] count_next = count_reg + CW'(push) - CW'(pop);

  assign o_in_ready = ready_reg;
  assign o_out_valid = valid_reg;
  assign o_out_data = mem[rd_ptr_reg];

  always_ff @(posedge i_clk) begin
    if (i_ce && push) begin
      mem[wr_ptr_reg] <= i_in_data;
    end
  end

  // flags are registered so ready and valid never ripple through
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      ready_reg <= 1'b0;
      valid_reg <= 1'b0;
    end else if (i_ce) begin
      if (push) wr_ptr_reg <= (wr_ptr_reg == LAST) ? '0 : wr_ptr_reg + 1'b1;
      if (pop) rd_ptr_reg <= (rd_ptr_reg == LAST) ? '0 : rd_ptr_reg + 1'b1;
      count_reg <= count_next;
      ready_reg <= count_next != FULL;
      valid_reg <= count_next != '0;
    end
  end
endmodule

//--- hw/spdc_trailer_gen.sv
// bit serialiser that appends the configured trailer after the last byte
`timescale 1ns/10ps
module spdc_trailer_gen (
  // clock
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_bit_tick,
  // byte source
  input wire logic i_valid,
  input wire spdc_pkg::spdc_byte_t i_word,
  output logic o_ready,
  // configuration
  input wire logic [7:0] i_cfg,
  // bit stream
  output logic o_bit,
  output logic o_bit_valid
);
  typedef enum logic [1:0] {ST_IDLE, ST_DATA, ST_TRAIL} spdc_trl_state_t;

  spdc_trl_state_t state_reg;
  logic [7:0] shift_reg;
  logic [2:0] bit_cnt_reg;
  logic last_reg;
  logic [3:0] trail_cnt_reg;
  logic phase_reg;
  logic first_reg;
  logic bit_reg;
  logic vld_reg;

  wire cfg_en = i_cfg[spdc_pkg::SPDC_TRL_EN_BIT];
  wire [1:0] cfg_pat = i_cfg[spdc_pkg::SPDC_TRL_PAT_LSB +: 2];
  wire [2:0] cfg_len = i_cfg[spdc_pkg::SPDC_TRL_LEN_LSB +: 3];
  wire [3:0] trail_len = {cfg_len, 1'b0};
  // reserved pattern code sends no trailer
  wire trail_on = cfg_en && cfg_len != 3'h0 && cfg_pat != spdc_pkg::SPDC_PAT_RSV;
  wire first_bit = (cfg_pat == spdc_pkg::SPDC_PAT_CRC) ? shift_reg[7] :
                   (cfg_pat == spdc_pkg::SPDC_PAT_10);
  wire byte_end = state_reg == ST_DATA && i_bit_tick && bit_cnt_reg == 3'h7;

  assign o_ready = state_reg == ST_IDLE;
  assign o_bit = bit_reg;
  assign o_bit_valid = vld_reg;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= ST_IDLE;
      shift_reg <= 8'h00;
      bit_cnt_reg <= 3'h0;
      last_reg <= 1'b0;
      trail_cnt_reg <= 4'h0;
      phase_reg <= 1'b0;
      first_reg <= 1'b0;
      bit_reg <= 1'b0;
      vld_reg <= 1'b0;
    end else if (i_ce) begin
      vld_reg <= 1'b0;
      unique case (state_reg)
        ST_IDLE: begin
          if (i_valid) begin
            shift_reg <= i_word.data;
            last_reg <= i_word.last;
            bit_cnt_reg <= 3'h0;
            state_reg <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (i_bit_tick) begin
            bit_reg <= shift_reg[7];
            vld_reg <= 1'b1;
            shift_reg <= {shift_reg[6:0], 1'b0};
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (byte_end) begin
              state_reg <= (last_reg && trail_on) ? ST_TRAIL : ST_IDLE;
              trail_cnt_reg <= trail_len;
              phase_reg <= 1'b0;
              first_reg <= first_bit;
            end
          end
        end
        ST_TRAIL: begin
          if (i_bit_tick) begin
            bit_reg <= first_reg ^ phase_reg;
            vld_reg <= 1'b1;
            phase_reg <= ~phase_reg;
            trail_cnt_reg <= trail_cnt_reg - 4'h1;
            if (trail_cnt_reg == 4'h1) state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  AST_TRAIL_LEN: assert property (
    i_ce && byte_end && last_reg && trail_on |=> state_reg == ST_TRAIL && trail_cnt_reg == $past(trail_len))
    else $error("trailer bit count is not twice the length field");
  AST_NO_TRAIL: assert property (
    i_ce && byte_end && !cfg_en |=> state_reg == ST_IDLE)
    else $error("trailer sent while disabled");
  AST_PATTERN: assert property (
    i_ce && state_reg == ST_TRAIL && i_bit_tick && first_reg != phase_reg |=> vld_reg && bit_reg)
    else $error("trailer bit does not follow the pattern");
endmodule

//--- hw/spdc_ctrl.sv
// register file, sync acceptance, diversity capture and tx trailer path
`timescale 1ns/10ps
module spdc_ctrl #(
  parameter int FIFO_DEPTH = 8
) (
  // clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // register port from the serial host interface
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  // transmit byte stream
  input wire logic i_tx_valid,
  input wire spdc_pkg::spdc_byte_t i_tx_word,
  output logic o_tx_ready,
  // transmit bit stream
  input wire logic i_bit_tick,
  output logic o_tx_bit,
  output logic o_tx_bit_valid,
  // sync detection
  input wire spdc_pkg::spdc_sync_t i_sync,
  output logic o_sync_detect,
  output logic [5:0] o_preamble_check_length,
  output logic o_sync_energy_check_enable,
  // diversity search
  input wire logic i_div_search_start,
  input wire logic i_div_search_done,
  input wire logic [1:0] i_div_antenna,
  input wire logic [7:0] i_ant1_energy,
  input wire logic [7:0] i_ant2_energy,
  input wire logic i_div_flag_clear,
  output logic o_diversity_enable,
  // antenna switches
  input wire logic i_tx_active,
  output logic o_antenna_select_output,
  output logic o_antenna_select_output_b,
  output logic o_txrx_switch_output
);
  //------------------------------------------------------------
  // registers
  //------------------------------------------------------------
  logic [7:0] trailer_config_reg;
  logic [7:0] rx_sync_condition_a_reg;
  logic [7:0] rx_sync_energy_threshold_reg;
  logic [7:0] rx_sync_error_tolerance_reg;
  logic [7:0] antenna_diversity_control_reg;
  logic [4:0] result_rsv_reg;
  logic [1:0] chosen_antenna_reg;
  logic search_done_reg;
  logic [7:0] first_antenna_energy_reg;
  logic [7:0] second_antenna_energy_reg;
  logic [7:0] rdata_reg;
  logic sync_detect_reg;
  logic [5:0] pre_len_reg;
  logic ant_sel_reg;
  logic ant_sel_b_reg;
  logic txrx_reg;

  //------------------------------------------------------------
  // address decode
  //------------------------------------------------------------
  wire wr_trailer = i_reg_wr && i_reg_addr == spdc_pkg::SPDC_ADDR_TRAILER;
  wire wr_cond_a = i_reg_wr && i_reg_addr == spdc_pkg::SPDC_ADDR_COND_A;
  wire wr_energy_th = i_reg_wr && i_reg_addr == spdc_pkg::SPDC_ADDR_ENERGY_TH;
  wire wr_tol = i_reg_wr && i_reg_addr == spdc_pkg::SPDC_ADDR_TOL;
  wire wr_div_ctl = i_reg_wr && i_reg_addr == spdc_pkg::SPDC_ADDR_DIV_CTL;
  wire wr_div_res = i_reg_wr && i_reg_addr == spdc_pkg::SPDC_ADDR_DIV_RES;

  //------------------------------------------------------------
  // field views
  //------------------------------------------------------------
  wire energy_check_en = rx_sync_condition_a_reg[spdc_pkg::SPDC_ENERGY_EN_BIT];
  wire [5:0] pre_len_raw = rx_sync_condition_a_reg[5:0];
  wire [3:0] sw_tol = rx_sync_error_tolerance_reg[spdc_pkg::SPDC_SW_TOL_LSB +: 4];
  wire [3:0] pb_tol = rx_sync_error_tolerance_reg[spdc_pkg::SPDC_PB_TOL_LSB +: 4];
  wire div_en = antenna_diversity_control_reg[spdc_pkg::SPDC_DIV_EN_BIT];
  wire dpdt = antenna_diversity_control_reg[spdc_pkg::SPDC_SW_TYPE_BIT];
  wire inv_trx = antenna_diversity_control_reg[spdc_pkg::SPDC_INV_TRX_BIT];
  wire inv_ant = antenna_diversity_control_reg[spdc_pkg::SPDC_INV_ANT_BIT];

  //------------------------------------------------------------
  // sync acceptance
  //------------------------------------------------------------
  wire [5:0] pre_len_eff = (pre_len_raw > spdc_pkg::SPDC_PRE_LEN_MAX) ?
                           spdc_pkg::SPDC_PRE_LEN_MAX : pre_len_raw;
  wire pre_ok = i_sync.pre_errs <= {2'h0, pb_tol};
  wire sw_ok = i_sync.sw_errs <= {2'h0, sw_tol};
  // strictly above: an energy equal to the threshold still blocks sync
  wire energy_ok = !energy_check_en || i_sync.energy > rx_sync_energy_threshold_reg;
  wire sync_accept = i_sync.candidate && pre_ok && sw_ok && energy_ok;
  wire result_valid = i_div_antenna == spdc_pkg::SPDC_ANT1 || i_div_antenna == spdc_pkg::SPDC_ANT2;
  wire ant_is_two = div_en && chosen_antenna_reg == spdc_pkg::SPDC_ANT2;
  wire ant_level = ant_is_two ^ inv_ant;

  //------------------------------------------------------------
  // read mux
  //------------------------------------------------------------
  wire [7:0] res_word = {search_done_reg, result_rsv_reg, chosen_antenna_reg};
  wire [7:0] rd_mux =
    (i_reg_addr == spdc_pkg::SPDC_ADDR_TRAILER) ? trailer_config_reg :
    (i_reg_addr == spdc_pkg::SPDC_ADDR_COND_A) ? rx_sync_condition_a_reg :
    (i_reg_addr == spdc_pkg::SPDC_ADDR_ENERGY_TH) ? rx_sync_energy_threshold_reg :
    (i_reg_addr == spdc_pkg::SPDC_ADDR_TOL) ? rx_sync_error_tolerance_reg :
    (i_reg_addr == spdc_pkg::SPDC_ADDR_DIV_CTL) ? antenna_diversity_control_reg :
    (i_reg_addr == spdc_pkg::SPDC_ADDR_DIV_RES) ? res_word :
    (i_reg_addr == spdc_pkg::SPDC_ADDR_ANT1_ENERGY) ? first_antenna_energy_reg :
    (i_reg_addr == spdc_pkg::SPDC_ADDR_ANT2_ENERGY) ? second_antenna_energy_reg :
    8'h00;

  //------------------------------------------------------------
  // writable configuration
  //------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      trailer_config_reg <= spdc_pkg::SPDC_RST_TRAILER;
      rx_sync_condition_a_reg <= spdc_pkg::SPDC_RST_ZERO;
      rx_sync_energy_threshold_reg <= spdc_pkg::SPDC_RST_ZERO;
      rx_sync_error_tolerance_reg <= spdc_pkg::SPDC_RST_ZERO;
      antenna_diversity_control_reg <= spdc_pkg::SPDC_RST_ZERO;
      result_rsv_reg <= 5'h00;
    end else if (i_ce) begin
      if (wr_trailer) trailer_config_reg <= i_reg_wdata;
      if (wr_cond_a) rx_sync_condition_a_reg <= i_reg_wdata;
      if (wr_energy_th) rx_sync_energy_threshold_reg <= i_reg_wdata;
      if (wr_tol) rx_sync_error_tolerance_reg <= i_reg_wdata;
      if (wr_div_ctl) antenna_diversity_control_reg <= i_reg_wdata;
      if (wr_div_res) result_rsv_reg <= i_reg_wdata[spdc_pkg::SPDC_RSV_LSB +: 5];
    end
  end

  //------------------------------------------------------------
  // diversity status
  //------------------------------------------------------------
  // completion wins over a start arriving in the same cycle
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      search_done_reg <= 1'b0;
      chosen_antenna_reg <= spdc_pkg::SPDC_RST_RESULT;
    end else if (i_ce) begin
      if (i_div_search_done) search_done_reg <= 1'b1;
      else if (i_div_search_start) search_done_reg <= 1'b0;
      if (sync_accept && result_valid) chosen_antenna_reg <= i_div_antenna;
    end
  end

  // a capture in the clearing cycle wins, so a fresh packet is not lost
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      first_antenna_energy_reg <= 8'h00;
      second_antenna_energy_reg <= 8'h00;
    end else if (i_ce) begin
      if (sync_accept && div_en) begin
        first_antenna_energy_reg <= i_ant1_energy;
        second_antenna_energy_reg <= i_ant2_energy;
      end else if (i_div_flag_clear) begin
        first_antenna_energy_reg <= 8'h00;
        second_antenna_energy_reg <= 8'h00;
      end
    end
  end

  //------------------------------------------------------------
  // registered outputs
  //------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_reg <= 8'h00;
      sync_detect_reg <= 1'b0;
      pre_len_reg <= 6'h00;
    end else if (i_ce) begin
      if (i_reg_rd) rdata_reg <= rd_mux;
      sync_detect_reg <= sync_accept;
      pre_len_reg <= pre_len_eff;
    end
  end

  // dpdt drives the second pole as the complement, spdt leaves it low
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ant_sel_reg <= 1'b0;
      ant_sel_b_reg <= 1'b0;
      txrx_reg <= 1'b0;
    end else if (i_ce) begin
      ant_sel_reg <= ant_level;
      ant_sel_b_reg <= dpdt && !ant_level;
      txrx_reg <= i_tx_active ^ inv_trx;
    end
  end

  assign o_reg_rdata = rdata_reg;
  assign o_sync_detect = sync_detect_reg;
  assign o_preamble_check_length = pre_len_reg;
  assign o_sync_energy_check_enable = rx_sync_condition_a_reg[spdc_pkg::SPDC_ENERGY_EN_BIT];
  assign o_diversity_enable = antenna_diversity_control_reg[spdc_pkg::SPDC_DIV_EN_BIT];
  assign o_antenna_select_output = ant_sel_reg;
  assign o_antenna_select_output_b = ant_sel_b_reg;
  assign o_txrx_switch_output = txrx_reg;

  //------------------------------------------------------------
  // transmit path
  //------------------------------------------------------------
  // the fifo decouples the byte source from the bit rate and stalls it
  spdc_pkg::spdc_byte_t fifo_word;
  logic fifo_valid;
  logic ser_ready;

  spdc_fifo #(
    .WIDTH($bits(spdc_pkg::spdc_byte_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_in_valid(i_tx_valid),
    .i_in_data(i_tx_word),
    .o_in_ready(o_tx_ready),
    .o_out_valid(fifo_valid),
    .o_out_data(fifo_word),
    .i_out_ready(ser_ready)
  );

  spdc_trailer_gen u_trailer (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_bit_tick(i_bit_tick),
    .i_valid(fifo_valid),
    .i_word(fifo_word),
    .o_ready(ser_ready),
    .i_cfg(trailer_config_reg),
    .o_bit(o_tx_bit),
    .o_bit_valid(o_tx_bit_valid)
  );

  //------------------------------------------------------------
  // checks
  //------------------------------------------------------------
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  AST_PRE_LEN_CLAMP: assert property (
    i_ce && wr_cond_a && i_reg_wdata[5:0] > 6'h20 ##1 i_ce |=> o_preamble_check_length == 6'h20)
    else $error("preamble check length not clamped to 32");
  AST_ENERGY_GATE: assert property (
    i_ce && energy_check_en && i_sync.energy <= rx_sync_energy_threshold_reg |=> !o_sync_detect)
    else $error("sync detected with energy not above threshold");
  AST_ENERGY_OFF: assert property (
    i_ce && !energy_check_en && i_sync.candidate && pre_ok && sw_ok |=> o_sync_detect)
    else $error("energy check applied while disabled");
  AST_SW_TOL: assert property (
    i_ce && i_sync.sw_errs > {2'h0, sw_tol} |=> !o_sync_detect)
    else $error("sync word accepted beyond tolerance");
  AST_PB_TOL: assert property (
    i_ce && i_sync.pre_errs > {2'h0, pb_tol} |=> !o_sync_detect)
    else $error("preamble accepted beyond tolerance");
  AST_RESULT: assert property (
    i_ce && sync_accept && result_valid |=> chosen_antenna_reg == $past(i_div_antenna))
    else $error("diversity result not refreshed at sync");
  AST_ENERGY_CAP: assert property (
    i_ce && sync_accept && div_en |=> first_antenna_energy_reg == $past(i_ant1_energy)
      && second_antenna_energy_reg == $past(i_ant2_energy))
    else $error("antenna energies not captured at sync");
  AST_ENERGY_CLR: assert property (
    i_ce && i_div_flag_clear && !(sync_accept && div_en) |=> first_antenna_energy_reg == 8'h00
      && second_antenna_energy_reg == 8'h00)
    else $error("antenna energies not cleared with the flag");
  AST_DONE: assert property (
    i_ce && i_div_search_start && !i_div_search_done |=> !search_done_reg)
    else $error("done bit set while search runs");
  AST_TXRX_POL: assert property (
    i_ce && inv_trx && i_tx_active |=> !o_txrx_switch_output)
    else $error("tx/rx switch polarity not inverted");
  AST_TRX_PLAIN: assert property (
    i_ce && !inv_trx |=> o_txrx_switch_output == $past(i_tx_active))
    else $error("tx/rx switch level differs from transmit state");
  AST_ACCEPT: assert property (
    i_ce && i_sync.candidate && pre_ok && sw_ok && energy_ok |=> o_sync_detect)
    else $error("sync within tolerance not detected");
  AST_RESULT_HOLD: assert property (
    i_ce && sync_accept && !result_valid |=> $stable(chosen_antenna_reg))
    else $error("diversity result took an illegal antenna code");
  AST_DONE_SET: assert property (
    i_ce && i_div_search_done |=> search_done_reg)
    else $error("done bit not set when the search completed");
  // switch levels follow the control bits one cycle later
  AST_ANT_SEL: assert property (
    i_ce && !div_en && !inv_ant |=> !o_antenna_select_output)
    else $error("antenna select driven with diversity off");
  AST_SPDT: assert property (
    i_ce && !dpdt |=> !o_antenna_select_output_b)
    else $error("second pole driven with a single-pole switch");
  AST_DPDT: assert property (
    i_ce && dpdt |=> o_antenna_select_output_b != o_antenna_select_output)
    else $error("second pole not the complement with a double-pole switch");
  // the captured energies are read-only, a host write must not disturb them
  AST_RO_ENERGY: assert property (
    i_ce && i_reg_wr && !(sync_accept && div_en) && !i_div_flag_clear
      && (i_reg_addr == spdc_pkg::SPDC_ADDR_ANT1_ENERGY || i_reg_addr == spdc_pkg::SPDC_ADDR_ANT2_ENERGY)
      |=> $stable(first_antenna_energy_reg) && $stable(second_antenna_energy_reg))
    else $error("read-only antenna energy changed by a host write");
endmodule

//--- testbench/spdc_host_model.sv
// host side of the register port: strobed single-cycle writes and reads
`timescale 1ns/10ps
module spdc_host_model (
  // clock
  input wire logic i_clk,
  // register port
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata,
  input wire logic [7:0] i_rdata
);
  //----------------------------------------
  // access tasks
  //----------------------------------------
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 8'h00;
    o_wdata = 8'h00;
  end
  // address and data are scrambled once the strobe drops so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk) #2;
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(posedge i_clk) #2;
    o_wr = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk) #2;
    o_addr = a;
    o_rd = 1'b1;
    @(posedge i_clk) #2;
    o_rd = 1'b0;
    o_addr = ~a;
    d = i_rdata;
  endtask
endmodule

//--- testbench/test_spdc_ctrl.sv
// self-checking bench for the trailer, sync condition and diversity block
`timescale 1ns/10ps
module test_spdc_ctrl;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic wr, rd, txv, start, done, clr, act, ok, run;
  logic tick = 1'b0;
  logic ce = 1'b1;
  logic tx_ready, tx_bit, tx_bv, det, nrg_en, div_en, a_sel, a_b, trx;
  logic [7:0] addr, wd, rdat, r, e1, e2;
  logic [5:0] plen;
  logic [1:0] ant;
  logic [1:0] tc = 2'b00;
  spdc_pkg::spdc_byte_t word;
  spdc_pkg::spdc_sync_t sy;
  logic [7:0] m [8];
  logic q [$];
  int bad_count = 0;
  int checked = 0;
  int n;
  always #20 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    #2;
    tc = tc + 2'b01;
    tick = run && tc == 2'b00;
  end
  spdc_host_model spdc_host_model_inst (.i_clk(i_clk), .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wd),
    .i_rdata(rdat));
  spdc_ctrl #(.FIFO_DEPTH(8)) spdc_ctrl_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(ce), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wd), .o_reg_rdata(rdat), .i_tx_valid(txv), .i_tx_word(word),
    .o_tx_ready(tx_ready), .i_bit_tick(tick), .o_tx_bit(tx_bit), .o_tx_bit_valid(tx_bv), .i_sync(sy),
    .o_sync_detect(det), .o_preamble_check_length(plen), .o_sync_energy_check_enable(nrg_en),
    .i_div_search_start(start), .i_div_search_done(done), .i_div_antenna(ant), .i_ant1_energy(e1),
    .i_ant2_energy(e2), .i_div_flag_clear(clr), .o_diversity_enable(div_en), .i_tx_active(act),
    .o_antenna_select_output(a_sel), .o_antenna_select_output_b(a_b), .o_txrx_switch_output(trx));
  //----------------------------------------
  // compare, model and closing tasks
  //----------------------------------------
  task automatic chk_reg(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value at %0t: byte %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_pin(input logic g, input logic e);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value at %0t: pin %b expected %b", $time, g, e);
    end
  endtask
  task automatic mw(input logic [7:0] a, input logic [7:0] d);
    spdc_host_model_inst.wr(a, d);
    if (a >= 8'h44 && a <= 8'h48) m[a - 8'h44] = d;
    if (a == 8'h49) m[5][6:2] = d[6:2];
  endtask
  task automatic rdall;
    for (int a = 8'h44; a < 8'h4d; a++) begin
      spdc_host_model_inst.rd(8'(a), r);
      chk_reg(r, a < 8'h4c ? m[a - 8'h44] : 8'h00);
    end
    chk_reg({2'b00, plen}, m[1][5:0] > 6'h20 ? 8'h20 : {2'b00, m[1][5:0]});
    chk_pin(nrg_en, m[1][7]);
    chk_pin(div_en, m[4][0]);
    chk_pin(a_sel, (m[4][0] && m[5][1:0] == 2'h2) ^ m[4][3]);
    chk_pin(a_b, m[4][1] && !((m[4][0] && m[5][1:0] == 2'h2) ^ m[4][3]));
    chk_pin(trx, act ^ m[4][2]);
  endtask
  task automatic end_sim;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    {txv, start, done, clr, act, ant, e1, e2, run} = '0;
    word = '0;
    sy = '0;
    m = '{8'h12, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
    repeat (20) @(posedge i_clk);
    #2 i_rst_n = 1'b1;
    r = 8'($urandom(13806));
    rdall();
    // a short check length keeps clear of the receiver's frequency settling
    mw(8'h45, 8'h08);
    // random register traffic, sync candidates near each threshold, search and flag events
    for (int k = 0; k < 60; k++) begin
      act = 1'($urandom);
      for (int a = 8'h44; a < 8'h4d; a++) mw(8'(a), 8'($urandom));
      @(posedge i_clk) #2;
      sy = '{1'b1, 6'(m[3][3:0] + $urandom % 3 - 1), 6'(m[3][7:4] + $urandom % 3 - 1), 8'(m[2] + $urandom % 3 - 1)};
      {ant, e1, e2, start, done} = 20'($urandom);
      ok = sy.pre_errs <= m[3][3:0] && sy.sw_errs <= m[3][7:4] && (!m[1][7] || sy.energy > m[2]);
      @(posedge i_clk) #2;
      chk_pin(det, ok);
      if (ok && (ant == 2'h1 || ant == 2'h2)) m[5][1:0] = ant;
      if (ok && m[4][0]) {m[6], m[7]} = {e1, e2};
      if (start) m[5][7] = 1'b0;
      if (done) m[5][7] = 1'b1;
      {sy.candidate, start, done} = 3'b000;
      // a frozen cycle must swallow the flag clear
      clr = 1'($urandom);
      ce = 1'($urandom);
      @(posedge i_clk) #2;
      if (clr && ce) {m[6], m[7]} = 16'h0000;
      {clr, ce} = 2'b01;
      rdall();
    end
    // fill the queue with ticks stalled, then drain it bit by bit for each trailer pattern
    for (int k = 0; k < 5; k++) begin
      mw(8'h44, {1'b0, 3'($urandom), 1'b0, 2'(k), k != 4});
      n = 0;
      @(posedge i_clk) #2;
      word = '{8'($urandom), 1'b1};
      txv = 1'b1;
      while (tx_ready === 1'b1 && n < 12) begin
        @(posedge i_clk) #2;
        n++;
        for (int i = 7; i >= 0; i--) q.push_back(word.data[i]);
        if (m[0][0] && m[0][6:4] != 3'h0 && m[0][2:1] != 2'h3)
          for (int i = 0; i < 2 * m[0][6:4]; i++) q.push_back((m[0][2:1] == 2'h2 ? word.data[0] : m[0][1]) ^ i[0]);
        word = '{8'($urandom), 1'b1};
      end
      txv = 1'b0;
      chk_pin(n == 8 || n == 9, 1'b1);
      run = 1'b1;
      repeat (1200) begin
        @(posedge i_clk) #2;
        if (tx_bv === 1'b1) chk_pin(tx_bit, q.size() > 0 ? q.pop_front() : ~tx_bit);
      end
      run = 1'b0;
      chk_reg(8'(q.size()), 8'h00);
      q.delete();
    end
    end_sim();
  end
endmodule
